// file: verilog/dac_output_soft_attenuator.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// [RULE_01] Two 7-bit level registers, left and right, bit 7 zero, reset 7F.
// [RULE_02] 128 levels per channel; code 127 is unity, lower codes attenuate more.
// [RULE_03] Linear level equals 2^m times (2l+33) minus 33.
// [RULE_04] Code zero maps to level zero; code 127 maps to 8031.
// [RULE_05] Applied linear level moves gradually toward a new target, never jumps. Here a mute drops it to zero in one cycle.
// [RULE_06] Applied level steps exactly one unit per sample period until equal.
// [RULE_07] Power-down pin low mutes; on release fade up to 7F over 8031 periods. Here the fade waits for the run bit to be set again, since pin low clears it.
// [RULE_08] DAC power bit cleared mutes; set again fades to programmed levels.
// [RULE_09] DAC run bit cleared mutes; set again fades to programmed levels.
// [RULE_10] Samples are 24-bit two's complement, zero is midscale.
// [RULE_11] Output scales with applied level; 8031 is unity, zero gives zero.
// [RULE_12] Registers are written only over the control port; no readback.
module dac_output_soft_attenuator #(
  parameter int SAMPLE_W = att_pkg::SAMPLE_W
) (
  // Clock, reset, enable
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       ce_i,
  // Power-down pin, asynchronous
  input  wire logic                       power_down_pin_n_i,
  // Control port writes
  input  wire logic                       wr_en_i,
  input  wire logic [4:0]                 wr_addr_i,
  input  wire logic [7:0]                 wr_data_i,
  // Sample stream in
  input  wire logic                       sample_valid_i,
  input  wire logic signed [SAMPLE_W-1:0] left_sample_i,
  input  wire logic signed [SAMPLE_W-1:0] right_sample_i,
  // Sample stream out
  output var  logic                       sample_valid_o,
  output var  logic signed [SAMPLE_W-1:0] left_sample_o,
  output var  logic signed [SAMPLE_W-1:0] right_sample_o,
  // Applied linear levels
  output var  logic [12:0]                left_level_o,
  output var  logic [12:0]                right_level_o
);

  logic       pin_meta;
  logic       pin_sync;
  logic [6:0] left_level_code;
  logic [6:0] right_level_code;
  logic       dac_power_enable_bit;
  logic       dac_run_bit;
  logic       force_mute;
  logic       wr_ok;

  att_chan_if #(.SAMPLE_W(SAMPLE_W)) left_bus ();
  att_chan_if #(.SAMPLE_W(SAMPLE_W)) right_bus ();

  // ----------------------------------------
  // Power-down pin synchroniser
  // ----------------------------------------
  // Resets to the powered-down state so the block starts muted
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else if (ce_i) begin
      pin_meta <= power_down_pin_n_i;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Writes while the pin holds power-down are lost, the file is in reset
  assign wr_ok = ce_i && wr_en_i && pin_sync; // RULE_12

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      left_level_code  <= att_pkg::ATT_RESET;
      right_level_code <= att_pkg::ATT_RESET;
    end else if (ce_i && !pin_sync) begin
      left_level_code  <= att_pkg::ATT_RESET; // RULE_07
      right_level_code <= att_pkg::ATT_RESET; // RULE_07
    end else if (wr_ok && wr_addr_i == att_pkg::ADDR_LEFT_ATT) begin
      left_level_code  <= wr_data_i[6:0]; // RULE_01 RULE_02
    end else if (wr_ok && wr_addr_i == att_pkg::ADDR_RIGHT_ATT) begin
      right_level_code <= wr_data_i[6:0]; // RULE_01 RULE_02
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dac_power_enable_bit <= att_pkg::POWER_RESET;
      dac_run_bit          <= att_pkg::RUN_RESET;
    end else if (ce_i && !pin_sync) begin
      dac_power_enable_bit <= att_pkg::POWER_RESET;
      dac_run_bit          <= att_pkg::RUN_RESET;
    end else if (wr_ok && wr_addr_i == att_pkg::ADDR_POWER) begin
      dac_power_enable_bit <= wr_data_i[att_pkg::POWER_BIT_POS]; // RULE_08
    end else if (wr_ok && wr_addr_i == att_pkg::ADDR_RESET_CTL) begin
      dac_run_bit          <= wr_data_i[att_pkg::RUN_BIT_POS]; // RULE_09
    end
  end

  // ----------------------------------------
  // Channel control
  // ----------------------------------------
  // Registers keep their codes under the bits, so release fades back to them
  assign force_mute = !pin_sync || !dac_power_enable_bit || !dac_run_bit; // RULE_07 RULE_08 RULE_09

  assign left_bus.code    = left_level_code;
  assign left_bus.mute    = force_mute;
  assign left_bus.strobe  = sample_valid_i;
  assign left_bus.din     = left_sample_i; // RULE_10
  assign right_bus.code   = right_level_code;
  assign right_bus.mute   = force_mute;
  assign right_bus.strobe = sample_valid_i;
  assign right_bus.din    = right_sample_i; // RULE_10

  att_channel #(.SAMPLE_W(SAMPLE_W)) u_left (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .bus      (left_bus.chan)
  );

  att_channel #(.SAMPLE_W(SAMPLE_W)) u_right (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .bus      (right_bus.chan)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sample_valid_o <= 1'b0;
    end else if (ce_i) begin
      sample_valid_o <= sample_valid_i;
    end
  end

  assign left_sample_o  = left_bus.dout;
  assign right_sample_o = right_bus.dout;
  assign left_level_o   = left_bus.level;
  assign right_level_o  = right_bus.level;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  left_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_01
    wr_ok && wr_addr_i == att_pkg::ADDR_LEFT_ATT |=> left_level_code == $past(wr_data_i[6:0]))
    else $error("left level write not stored");
  right_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_01
    wr_ok && wr_addr_i == att_pkg::ADDR_RIGHT_ATT |=> right_level_code == $past(wr_data_i[6:0]))
    else $error("right level write not stored");
  pin_reset_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_07
    ce_i && !pin_sync |=> left_level_code == att_pkg::ATT_RESET
      && right_level_code == att_pkg::ATT_RESET
      && left_level_o == 13'h0000 && right_level_o == 13'h0000)
    else $error("power-down pin did not reset and mute");
  power_mute_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_08
    ce_i && !dac_power_enable_bit |=> left_level_o == 13'h0000 && right_level_o == 13'h0000)
    else $error("power bit did not mute");
  run_mute_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_09
    ce_i && !dac_run_bit |=> left_level_o == 13'h0000 && right_level_o == 13'h0000)
    else $error("run bit did not mute");
  fade_start_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_05
    ce_i && !force_mute && sample_valid_i && left_level_o == 13'h0000 && left_level_code != 7'h00
    |=> left_level_o == 13'h0001)
    else $error("fade did not start from zero by one");
  valid_out_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i |=> sample_valid_o == $past(sample_valid_i))
    else $error("output valid not one cycle after input");

  // ----------------------------------------
  // Ramp and register file checks
  // ----------------------------------------
  // Right channel has its own ramp, so it is checked on its own
  right_fade_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_05
    ce_i && !force_mute && sample_valid_i && right_level_o == 13'h0000
    && right_level_code != 7'h00 |=> right_level_o == 13'h0001)
    else $error("right fade did not start from zero by one");
  left_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_06
    ce_i && !force_mute && !sample_valid_i |=> left_level_o == $past(left_level_o))
    else $error("left level moved without a strobe");
  right_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_06
    ce_i && !force_mute && !sample_valid_i |=> right_level_o == $past(right_level_o))
    else $error("right level moved without a strobe");

  left_step_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_06
    ce_i && !force_mute |=> left_level_o == $past(left_level_o)
      || left_level_o == $past(left_level_o) + 13'h0001
      || left_level_o == $past(left_level_o) - 13'h0001)
    else $error("left level moved more than one");
  right_step_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_06
    ce_i && !force_mute |=> right_level_o == $past(right_level_o)
      || right_level_o == $past(right_level_o) + 13'h0001
      || right_level_o == $past(right_level_o) - 13'h0001)
    else $error("right level moved more than one");
  level_bound_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_05
    left_level_o <= att_pkg::LEVEL_MAX && right_level_o <= att_pkg::LEVEL_MAX)
    else $error("applied level above full scale");

  other_addr_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_12
    wr_ok && wr_addr_i != att_pkg::ADDR_LEFT_ATT && wr_addr_i != att_pkg::ADDR_RIGHT_ATT
    |=> left_level_code == $past(left_level_code)
      && right_level_code == $past(right_level_code))
    else $error("write to another address changed a level");
  code_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_01
    ce_i && pin_sync && !wr_en_i |=> left_level_code == $past(left_level_code)
      && right_level_code == $past(right_level_code))
    else $error("level code changed without a write");
  power_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_08
    wr_ok && wr_addr_i == att_pkg::ADDR_POWER
    |=> dac_power_enable_bit == $past(wr_data_i[att_pkg::POWER_BIT_POS]))
    else $error("power bit write not stored");
  run_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_09
    wr_ok && wr_addr_i == att_pkg::ADDR_RESET_CTL
    |=> dac_run_bit == $past(wr_data_i[att_pkg::RUN_BIT_POS]))
    else $error("run bit write not stored");

  // Pin low must also return both control bits to their defaults
  pin_bits_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_07
    ce_i && !pin_sync |=> dac_power_enable_bit == att_pkg::POWER_RESET
      && dac_run_bit == att_pkg::RUN_RESET)
    else $error("power-down pin did not reset control bits");
  pin_sync_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_07
    ce_i |=> pin_sync == $past(pin_meta))
    else $error("pin synchroniser skipped a stage");
  out_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_11
    ce_i && !sample_valid_i |=> left_sample_o == $past(left_sample_o)
      && right_sample_o == $past(right_sample_o))
    else $error("output sample changed without a strobe");

endmodule
`default_nettype wire

// file: verilog/att_pkg.sv
package att_pkg;
  // ----------------------------------------
  // Control port addresses
  // ----------------------------------------
  localparam logic [4:0]  ADDR_POWER     = 5'h00;
  localparam logic [4:0]  ADDR_RESET_CTL = 5'h01;
  localparam logic [4:0]  ADDR_LEFT_ATT  = 5'h06;
  localparam logic [4:0]  ADDR_RIGHT_ATT = 5'h07;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int          POWER_BIT_POS  = 0;
  localparam int          RUN_BIT_POS    = 0;
  localparam int          CODE_W         = 7;
  localparam logic [6:0]  ATT_RESET      = 7'h7f;
  localparam logic        POWER_RESET    = 1'b1;
  localparam logic        RUN_RESET      = 1'b0;

  // ----------------------------------------
  // Linear level and scaling
  // ----------------------------------------
  localparam int          LEVEL_W        = 13;
  localparam logic [12:0] LEVEL_MAX      = 13'h1f5f;
  localparam logic [12:0] LEVEL_OFFSET   = 13'h0021;
  localparam int          SAMPLE_W       = 24;
  // Close to 2^26 / max level, a hair above so mid levels never exceed unity
  localparam logic [13:0] SCALE_K        = 14'h20a5;
  localparam int          SCALE_SHIFT    = 26;
endpackage

// file: verilog/att_chan_if.sv
`timescale 1ns/10ps
`default_nettype none
interface att_chan_if #(parameter int SAMPLE_W = 24);
  logic        [6:0]          code;
  logic                       mute;
  logic                       strobe;
  logic signed [SAMPLE_W-1:0] din;
  logic signed [SAMPLE_W-1:0] dout;
  logic        [12:0]         level;

  modport ctrl (output code, output mute, output strobe, output din,
                input dout, input level);
  modport chan (input code, input mute, input strobe, input din,
                output dout, output level);
endinterface
`default_nettype wire

// file: verilog/att_channel.sv
`timescale 1ns/10ps
`default_nettype none
module att_channel #(
  parameter int SAMPLE_W = 24
) (
  // Clock, reset and enable
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic ce_i,
  // Channel carrier
  att_chan_if.chan  bus
);

  logic        [12:0]         target;
  logic        [12:0]         level;
  logic signed [52:0]         prod;

  // ----------------------------------------
  // Code to linear level
  // ----------------------------------------
  function automatic logic [12:0] to_level(input logic [6:0] c);
    logic [12:0] base;
    base = {8'h00, c[3:0], 1'b0} + att_pkg::LEVEL_OFFSET;
    if (c == 7'h00) begin
      to_level = 13'h0000; // RULE_04
    end else begin
      to_level = 13'(base << c[6:4]) - att_pkg::LEVEL_OFFSET; // RULE_03
    end
  endfunction

  assign target    = to_level(bus.code);
  assign bus.level = level;

  // ----------------------------------------
  // Soft ramp, one unit per sample period
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level <= 13'h0000;
    end else if (ce_i) begin
      if (bus.mute) begin
        level <= 13'h0000; // RULE_07 RULE_08 RULE_09
      end else if (bus.strobe && level < target) begin
        level <= level + 13'h0001; // RULE_05 RULE_06
      end else if (bus.strobe && level > target) begin
        level <= level - 13'h0001; // RULE_06
      end
    end
  end

  // ----------------------------------------
  // Signed scaling
  // ----------------------------------------
  // Truncating shift rounds toward minus infinity; full level bypasses it
  assign prod = bus.din * $signed({1'b0, level}) * $signed({1'b0, att_pkg::SCALE_K}); // RULE_10

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus.dout <= '0;
    end else if (ce_i && bus.strobe) begin
      if (level == att_pkg::LEVEL_MAX) begin
        bus.dout <= bus.din; // RULE_11
      end else begin
        bus.dout <= prod[att_pkg::SCALE_SHIFT +: SAMPLE_W]; // RULE_11
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  step_up_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_06
    ce_i && bus.strobe && !bus.mute && level < target |=> level == $past(level) + 13'h0001)
    else $error("level did not rise by one");
  step_down_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_06
    ce_i && bus.strobe && !bus.mute && level > target |=> level == $past(level) - 13'h0001)
    else $error("level did not fall by one");
  mute_level_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_08
    ce_i && bus.mute |=> level == 13'h0000)
    else $error("mute did not clear level");
  max_code_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_04
    bus.code == 7'h7f |-> target == att_pkg::LEVEL_MAX)
    else $error("top code not full level");
  unity_pass_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_11
    ce_i && bus.strobe && level == att_pkg::LEVEL_MAX |=> bus.dout == $past(bus.din))
    else $error("full level not unity");
  zero_out_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE_11
    ce_i && bus.strobe && level == 13'h0000 |=> bus.dout == '0)
    else $error("zero level gave nonzero sample");

endmodule
`default_nettype wire

// file: dv/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic       clk_i,
  // Control port
  output var  logic       wr_en_o,
  output var  logic [4:0] wr_addr_o,
  output var  logic [7:0] wr_data_o
);
  initial begin
    wr_en_o   = 1'b0;
    wr_addr_o = 5'h00;
    wr_data_o = 8'h00;
  end
  // Write only, the port has no read path
  task automatic write(input logic [4:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    wr_en_o   = 1'b1;
    wr_addr_o = addr;
    wr_data_o = data;
    @(negedge clk_i);
    wr_en_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic               clk;
  logic               arst_n;
  logic               pin_n;
  logic               wr_en;
  logic [4:0]         wr_addr;
  logic [7:0]         wr_data;
  logic               valid_in;
  logic signed [23:0] left_in;
  logic signed [23:0] right_in;
  logic               valid_out;
  logic signed [23:0] left_out;
  logic signed [23:0] right_out;
  logic [12:0]        left_level;
  logic [12:0]        right_level;
  int                 num_errors;
  int                 samples_checked;
  int                 prev;
  int                 expl;
  logic [6:0]         codes [8] = '{7'h7e, 7'h70, 7'h5f, 7'h40, 7'h30, 7'h10, 7'h01, 7'h00};

  host_model host (.clk_i(clk), .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data));

  dac_output_soft_attenuator DUT (
    .clk_i(clk), .arst_n_i(arst_n), .ce_i(1'b1), .power_down_pin_n_i(pin_n),
    .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .sample_valid_i(valid_in), .left_sample_i(left_in), .right_sample_i(right_in),
    .sample_valid_o(valid_out), .left_sample_o(left_out), .right_sample_o(right_out),
    .left_level_o(left_level), .right_level_o(right_level));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic int lin(input logic [6:0] c);
    if (c === 7'h00) return 0;
    return ((2 * c[3:0] + 33) << c[6:4]) - 33;
  endfunction

  // Full level passes untouched, others floor after the multiply
  function automatic logic [23:0] scale(input longint d, input longint lvl);
    if (lvl == longint'(att_pkg::LEVEL_MAX)) return d[23:0];
    return 24'((d * lvl * longint'(att_pkg::SCALE_K)) >>> att_pkg::SCALE_SHIFT);
  endfunction

  task automatic check(input logic [23:0] seen, input logic [23:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic lv(input int l, input int r);
    check({11'h000, left_level}, 24'(l));
    check({11'h000, right_level}, 24'(r));
  endtask

  task automatic ramp(input int n);
    @(negedge clk);
    valid_in = 1'b1;
    repeat (n) @(negedge clk);
    valid_in = 1'b0;
  endtask

  task automatic send(input logic signed [23:0] d, input int l, input int r);
    @(negedge clk);
    valid_in = 1'b1;
    left_in  = d;
    right_in = -d;
    @(negedge clk);
    valid_in = 1'b0;
    check({23'h0, valid_out}, 24'h000001);
    check(left_out, scale(d, l));
    check(right_out, scale(-d, r));
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Four full fades plus margin
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    test_done();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    pin_n = 1'b1;
    valid_in = 1'b0;
    left_in = 24'sh000000;
    right_in = 24'sh000000;
    num_errors = 0;
    samples_checked = 0;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    lv(0, 0);
    host.write(att_pkg::ADDR_RESET_CTL, 8'h01);
    repeat (2) @(negedge clk);
    ramp(100);
    lv(100, 100);
    ramp(7931);
    lv(8031, 8031);
    send(24'sh123456, 8031, 8031);
    send(-24'sh7abcde, 8031, 8031);
    $display("test 1 done");
    host.write(5'h08, 8'h00);
    host.write(5'h02, 8'h00);
    host.write(att_pkg::ADDR_RIGHT_ATT, 8'hff);
    ramp(1);
    lv(8031, 8031);
    prev = 8031;
    foreach (codes[i]) begin
      expl = lin(codes[i]);
      host.write(att_pkg::ADDR_LEFT_ATT, {1'b0, codes[i]});
      repeat (2) @(negedge clk);
      ramp(1);
      lv(prev - 1, 8031);
      if (prev - expl > 1) ramp(prev - expl - 1);
      lv(expl, 8031);
      if (codes[i] === 7'h40) send(-24'sh400001, expl, 8031);
      prev = expl;
    end
    $display("test 2 done");
    host.write(att_pkg::ADDR_POWER, 8'h00);
    repeat (2) @(negedge clk);
    lv(0, 0);
    host.write(att_pkg::ADDR_LEFT_ATT, 8'h7f);
    host.write(att_pkg::ADDR_POWER, 8'h01);
    repeat (2) @(negedge clk);
    ramp(8031);
    lv(8031, 8031);
    host.write(att_pkg::ADDR_RESET_CTL, 8'h00);
    repeat (2) @(negedge clk);
    lv(0, 0);
    host.write(att_pkg::ADDR_RESET_CTL, 8'h01);
    repeat (2) @(negedge clk);
    ramp(5);
    lv(5, 5);
    $display("test 3 done");
    host.write(att_pkg::ADDR_LEFT_ATT, 8'h10);
    pin_n = 1'b0;
    repeat (4) @(negedge clk);
    lv(0, 0);
    host.write(att_pkg::ADDR_LEFT_ATT, 8'h00);
    pin_n = 1'b1;
    repeat (4) @(negedge clk);
    lv(0, 0);
    host.write(att_pkg::ADDR_RESET_CTL, 8'h01);
    repeat (2) @(negedge clk);
    ramp(8030);
    lv(8030, 8030);
    ramp(1);
    lv(8031, 8031);
    $display("test 4 done");
    test_done();
  end
endmodule
`default_nettype wire
